/* rtl/tsio_defs.svh */
// Constants for the terminal serial I/O sequencer
`ifndef TSIO_DEFS_SVH
`define TSIO_DEFS_SVH
`define TSIO_CLK_HZ       40000000
`define TSIO_OVERSAMPLE   16
`define TSIO_MEM_DEPTH    2048
`define TSIO_MEM_SHOWN    1920
`define TSIO_LINE_LEN     7'd80
`define TSIO_DATA_BITS    7
`define TSIO_BIT_PROT     7
`define TSIO_BIT_BLINK    8
`define TSIO_RX_MID       4'h7
`define TSIO_RX_LAST      4'hf
`define TSIO_SRC_MAIN     2'h0
`define TSIO_SRC_AUX      2'h1
`define TSIO_SRC_LOOP     2'h2
`define TSIO_STX          7'o002
`define TSIO_ETX          7'o003
`define TSIO_ESC          7'o033
`define TSIO_HT           7'o111
`define TSIO_CR           7'o015
`define TSIO_LF           7'o012
`define TSIO_AUX_STX      7'o002
`define TSIO_AUX_ETX      7'o003
`define TSIO_AUX_HT       7'o111
`define TSIO_AUX_CR       7'o015
`define TSIO_AUX_LF       7'o012
`define TSIO_FKEY_BASE    7'h40
`define TSIO_BREAK_MS     250
`define TSIO_RTS_HOLD_US  1000
`define TSIO_BAUD_0       75
`define TSIO_BAUD_1       110
`define TSIO_BAUD_2       150
`define TSIO_BAUD_3       300
`define TSIO_BAUD_4       600
`define TSIO_BAUD_5       1200
`define TSIO_BAUD_6       2400
`define TSIO_BAUD_7       4800
`define TSIO_BAUD_8       9600
`define TSIO_BAUD_9       19200
`endif

/* rtl/tsio_pkg.sv */
// Types for the terminal serial I/O sequencer
package tsio_pkg;
  typedef struct packed {
    logic [3:0] baud_sel;
    logic       parity_en;
    logic       parity_odd;
    logic       two_stop;
    logic       format_mode;
    logic       online;
    logic [1:0] rx_src;
  } tsio_cfg_s;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} tsio_rx_e;
  typedef enum logic [1:0] {WR_IDLE, WR_MUX, WR_WRITE, WR_CLEAR} tsio_wr_e;
  typedef enum logic [3:0] {
    SQ_IDLE, SQ_CTS, SQ_STX, SQ_RD, SQ_CHK, SQ_DATA, SQ_HT, SQ_CR, SQ_LF,
    SQ_ETX, SQ_DRAIN, SQ_HOLD, SQ_FESC, SQ_FCODE
  } tsio_seq_e;

  typedef struct packed {
    logic        busy;
    logic [10:0] shift;
    logic [3:0]  bits_left;
    logic [3:0]  sub;
  } tsio_tx_s;

  typedef struct packed {
    logic [15:0] div;
    logic        x8;
    tsio_rx_e    rx_st;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit;
    logic [6:0]  rx_char;
    logic        rx_full;
    tsio_wr_e    wr_st;
    logic        kb_pend;
    logic [6:0]  kb_char;
    logic        brk_prev;
    logic [31:0] brk_cnt;
    tsio_seq_e   sq_st;
    logic        sq_aux;
    logic        sq_fkey;
    logic        sq_rts;
    logic [10:0] sq_addr;
    logic [6:0]  sq_col;
    logic        sq_prot;
    logic [6:0]  sq_char;
    logic [31:0] hold_cnt;
    logic        route_aux;
    logic        dtr;
    logic        rd_valid;
  } tsio_state_s;
endpackage

/* rtl/tsio_top.sv */
// Serial I/O, page memory writer and send sequencers of a display terminal
`timescale 1ns/1ps
`default_nettype none
`include "tsio_defs.svh"
// Summary of operation
// - Page memory holds 2048 nine-bit words: 7 data, protect, blink.
// - Only the first 1920 words are shown; the other 128 are never written.
// - Received character: mux address to cursor, write strobe, then clear receiver.
// - Control may suspend refresh reads so the sequencer gets memory time.
// - Receiver input selects main line, aux line or looped-back transmit.
// - Bit clock divides from the system clock; switch picks 75 to 19200 baud.
// - Transmitter and receiver run at 16x baud; transmitter divides to bit rate.
// - Line data reaches receiver only while on-line; characters are seven bits.
// - Keyboard or bus seven bits feed transmitter; keyboard load starts sending.
// - Transmitter adds configured parity and one or two stop bits.
// - Transmit output loops back into the receiver through the source gating.
// - Data terminal ready reports status; request to send while data waits.
// - Host drives clear to send; transmit clock runs only while it is high.
// - Optional clock output at eight times the baud rate.
// - Break key starts a timer holding the main transmit line spacing for a fixed time.
// - Send key raises request to send, waits clear to send, then STX and data.
// - Field layout mode sends HT code at each protected field start and end.
// - Outside field layout mode each line end sends CR then LF.
// - Message end sends ETX, waits a timeout, then drops request to send.
// - Auxiliary send repeats block send through the auxiliary port.
// - Auxiliary send takes its delimiters from a separate lookup region.
// - Programmable key sends STX, ESC, the key code character, then ETX.
module tsio_top #(
  parameter int CLK_HZ      = `TSIO_CLK_HZ,
  parameter int BREAK_MS    = `TSIO_BREAK_MS,
  parameter int RTS_HOLD_US = `TSIO_RTS_HOLD_US
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire tsio_pkg::tsio_cfg_s cfg,
  input  wire logic              term_ready,
  input  wire logic              rxd_main,
  input  wire logic              rxd_aux,
  input  wire logic              cts,
  input  wire logic [6:0]        kbd_data,
  input  wire logic [6:0]        bus_data,
  input  wire logic              bus_sel,
  input  wire logic              kbd_load,
  input  wire logic              kbd_break_n,
  input  wire logic              send_key,
  input  wire logic              aux_send_key,
  input  wire logic              programmable_keys,
  input  wire logic [3:0]        programmable_key_index,
  input  wire logic [10:0]       cursor_addr,
  input  wire logic              rx_protect,
  input  wire logic              rx_blink,
  input  wire logic              refresh_req,
  input  wire logic              refresh_suspend,
  input  wire logic [10:0]       refresh_addr,
  output logic [8:0]             refresh_data,
  output logic                   refresh_valid,
  output logic                   mem_write,
  output logic                   txd_main,
  output logic                   txd_aux,
  output logic                   rts,
  output logic                   dtr,
  output logic                   clk_x8_out,
  output logic                   seq_busy
);
  localparam int BREAK_CYCLES = (CLK_HZ / 1000) * BREAK_MS;
  localparam int HOLD_CYCLES  = int'(longint'(CLK_HZ) * RTS_HOLD_US / 1000000);

  if (CLK_HZ < `TSIO_OVERSAMPLE * `TSIO_BAUD_9 || BREAK_CYCLES < 1 || HOLD_CYCLES < 1) begin : g_chk
    $error("tsio_top: clock or timing parameters out of range");
  end

  tsio_pkg::tsio_state_s s_q;
  tsio_pkg::tsio_state_s s_d;
  logic [8:0]            mem_q [`TSIO_MEM_DEPTH];
  logic [8:0]            rd_data_q;
  logic [10:0]           rd_addr;
  logic                  grant;
  logic                  tick;
  logic                  rx_in;
  logic                  tx_ready;
  logic                  tx_load;
  logic [6:0]            tx_char;
  logic                  tx_out;
  logic                  wr_en;
  logic                  brk_on;

  function automatic logic [15:0] div_for(input logic [3:0] sel);
    int rate;
    unique case (sel)
      4'h0:    rate = `TSIO_BAUD_0;
      4'h1:    rate = `TSIO_BAUD_1;
      4'h2:    rate = `TSIO_BAUD_2;
      4'h3:    rate = `TSIO_BAUD_3;
      4'h4:    rate = `TSIO_BAUD_4;
      4'h5:    rate = `TSIO_BAUD_5;
      4'h6:    rate = `TSIO_BAUD_6;
      4'h7:    rate = `TSIO_BAUD_7;
      4'h8:    rate = `TSIO_BAUD_8;
      default: rate = `TSIO_BAUD_9;
    endcase
    return 16'(CLK_HZ / (`TSIO_OVERSAMPLE * rate) - 1);
  endfunction

  // Delimiter lookup; aux send uses its own region
  function automatic logic [6:0] delim(input logic aux, input logic [2:0] which);
    logic [6:0] v;
    v = 7'h00;
    unique case (which)
      3'h0:    v = aux ? `TSIO_AUX_STX : `TSIO_STX;
      3'h1:    v = aux ? `TSIO_AUX_HT : `TSIO_HT;
      3'h2:    v = aux ? `TSIO_AUX_CR : `TSIO_CR;
      3'h3:    v = aux ? `TSIO_AUX_LF : `TSIO_LF;
      default: v = aux ? `TSIO_AUX_ETX : `TSIO_ETX;
    endcase
    return v;
  endfunction

  assign tick   = (s_q.div == 16'h0000);
  assign brk_on = (s_q.brk_cnt != 32'h0);
  assign grant  = refresh_suspend | ~refresh_req;

  always_comb begin
    unique case (cfg.rx_src)
      `TSIO_SRC_MAIN: rx_in = cfg.online ? rxd_main : 1'b1;
      `TSIO_SRC_AUX:  rx_in = cfg.online ? rxd_aux : 1'b1;
      `TSIO_SRC_LOOP: rx_in = tx_out;
      default:        rx_in = 1'b1;
    endcase
  end

  tsio_uart_tx u_tx (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .tick16     (tick),
    .cts        (cts),
    .load       (tx_load),
    .data       (tx_char),
    .parity_en  (cfg.parity_en),
    .parity_odd (cfg.parity_odd),
    .two_stop   (cfg.two_stop),
    .ready      (tx_ready),
    .txd        (tx_out)
  );

  always_comb begin
    s_d     = s_q;
    tx_load = 1'b0;
    tx_char = s_q.kb_char;
    wr_en   = 1'b0;
    rd_addr = refresh_addr;
    s_d.dtr = term_ready;

    // Bit clock divider and 8x clock
    s_d.div = tick ? div_for(cfg.baud_sel) : s_q.div - 16'h0001;
    if (tick) begin
      s_d.x8 = ~s_q.x8;
    end

    // Receiver at 16x oversampling
    if (tick) begin
      s_d.rx_sub = s_q.rx_sub + 4'h1;
      unique case (s_q.rx_st)
        tsio_pkg::RX_IDLE: begin
          s_d.rx_sub = 4'h0;
          if (!rx_in && !s_q.rx_full) begin
            s_d.rx_st = tsio_pkg::RX_START;
          end
        end
        tsio_pkg::RX_START: begin
          if (s_q.rx_sub == `TSIO_RX_MID) begin
            s_d.rx_sub = 4'h0;
            s_d.rx_bit = 4'h0;
            s_d.rx_st  = rx_in ? tsio_pkg::RX_IDLE : tsio_pkg::RX_DATA;
          end
        end
        tsio_pkg::RX_DATA: begin
          if (s_q.rx_sub == `TSIO_RX_LAST) begin
            s_d.rx_bit = s_q.rx_bit + 4'h1;
            if (s_q.rx_bit < 4'(`TSIO_DATA_BITS)) begin
              s_d.rx_char = {rx_in, s_q.rx_char[6:1]};
            end
            if (s_q.rx_bit == 4'(`TSIO_DATA_BITS - 1) + 4'(cfg.parity_en)) begin
              s_d.rx_st = tsio_pkg::RX_STOP;
            end
          end
        end
        tsio_pkg::RX_STOP: begin
          if (s_q.rx_sub == `TSIO_RX_LAST) begin
            s_d.rx_full = rx_in;
            s_d.rx_st   = tsio_pkg::RX_IDLE;
          end
        end
      endcase
    end

    // Store received character at the cursor
    unique case (s_q.wr_st)
      tsio_pkg::WR_IDLE:  if (s_q.rx_full) s_d.wr_st = tsio_pkg::WR_MUX;
      tsio_pkg::WR_MUX:   s_d.wr_st = tsio_pkg::WR_WRITE;
      tsio_pkg::WR_WRITE: begin
        wr_en     = (cursor_addr < 11'(`TSIO_MEM_SHOWN));
        s_d.wr_st = tsio_pkg::WR_CLEAR;
      end
      tsio_pkg::WR_CLEAR: begin
        s_d.rx_full = 1'b0;
        s_d.wr_st   = tsio_pkg::WR_IDLE;
      end
    endcase

    // Break timer on the falling edge of the break line
    s_d.brk_prev = kbd_break_n;
    if (s_q.brk_prev && !kbd_break_n) begin
      s_d.brk_cnt = 32'(BREAK_CYCLES);
    end else if (brk_on) begin
      s_d.brk_cnt = s_q.brk_cnt - 32'h1;
    end

    // Keyboard or bus character waiting for the transmitter
    if (kbd_load && !s_q.kb_pend) begin
      s_d.kb_pend = 1'b1;
      s_d.kb_char = bus_sel ? bus_data : kbd_data;
    end

    // Send sequencer
    unique case (s_q.sq_st)
      tsio_pkg::SQ_IDLE: begin
        s_d.route_aux = 1'b0;
        if (send_key || aux_send_key || programmable_keys) begin
          s_d.sq_rts  = 1'b1;
          s_d.sq_aux  = aux_send_key && !send_key;
          s_d.sq_fkey = programmable_keys && !send_key && !aux_send_key;
          s_d.sq_char = `TSIO_FKEY_BASE + {3'h0, programmable_key_index};
          s_d.sq_addr = 11'h000;
          s_d.sq_col  = 7'h00;
          s_d.sq_prot = 1'b0;
          s_d.sq_st   = tsio_pkg::SQ_CTS;
        end else if (s_q.kb_pend && tx_ready) begin
          tx_load     = 1'b1;
          s_d.kb_pend = 1'b0;
        end
      end
      tsio_pkg::SQ_CTS: begin
        if (cts && tx_ready) begin
          s_d.route_aux = s_q.sq_aux;
          s_d.sq_st     = tsio_pkg::SQ_STX;
        end
      end
      tsio_pkg::SQ_STX: begin
        if (tx_ready) begin
          tx_load   = 1'b1;
          tx_char   = delim(s_q.sq_aux, 3'h0);
          s_d.sq_st = s_q.sq_fkey ? tsio_pkg::SQ_FESC : tsio_pkg::SQ_RD;
        end
      end
      tsio_pkg::SQ_FESC: begin
        if (tx_ready) begin
          tx_load   = 1'b1;
          tx_char   = `TSIO_ESC;
          s_d.sq_st = tsio_pkg::SQ_FCODE;
        end
      end
      tsio_pkg::SQ_FCODE: begin
        if (tx_ready) begin
          tx_load   = 1'b1;
          tx_char   = s_q.sq_char;
          s_d.sq_st = tsio_pkg::SQ_ETX;
        end
      end
      tsio_pkg::SQ_RD: begin
        if (s_q.sq_addr == cursor_addr || s_q.sq_addr == 11'(`TSIO_MEM_SHOWN)) begin
          s_d.sq_st = tsio_pkg::SQ_ETX;
        end else if (grant && tx_ready) begin
          rd_addr   = s_q.sq_addr;
          s_d.sq_st = tsio_pkg::SQ_CHK;
        end
      end
      tsio_pkg::SQ_CHK: begin
        s_d.sq_char = rd_data_q[6:0];
        s_d.sq_prot = rd_data_q[`TSIO_BIT_PROT];
        if (cfg.format_mode && (s_q.sq_prot != rd_data_q[`TSIO_BIT_PROT])) begin
          s_d.sq_st = tsio_pkg::SQ_HT;
        end else begin
          s_d.sq_st = tsio_pkg::SQ_DATA;
        end
      end
      tsio_pkg::SQ_HT: begin
        if (tx_ready) begin
          tx_load   = 1'b1;
          tx_char   = delim(s_q.sq_aux, 3'h1);
          s_d.sq_st = tsio_pkg::SQ_DATA;
        end
      end
      tsio_pkg::SQ_DATA: begin
        if (tx_ready) begin
          tx_load     = !(cfg.format_mode && s_q.sq_prot);
          tx_char     = s_q.sq_char;
          s_d.sq_addr = s_q.sq_addr + 11'h001;
          s_d.sq_col  = s_q.sq_col + 7'h01;
          s_d.sq_st   = tsio_pkg::SQ_RD;
          if (s_q.sq_col == `TSIO_LINE_LEN - 7'h01) begin
            s_d.sq_col = 7'h00;
            if (!cfg.format_mode) begin
              s_d.sq_st = tsio_pkg::SQ_CR;
            end
          end
        end
      end
      tsio_pkg::SQ_CR: begin
        if (tx_ready) begin
          tx_load   = 1'b1;
          tx_char   = delim(s_q.sq_aux, 3'h2);
          s_d.sq_st = tsio_pkg::SQ_LF;
        end
      end
      tsio_pkg::SQ_LF: begin
        if (tx_ready) begin
          tx_load   = 1'b1;
          tx_char   = delim(s_q.sq_aux, 3'h3);
          s_d.sq_st = tsio_pkg::SQ_RD;
        end
      end
      tsio_pkg::SQ_ETX: begin
        if (tx_ready) begin
          tx_load   = 1'b1;
          tx_char   = delim(s_q.sq_aux, 3'h4);
          s_d.sq_st = tsio_pkg::SQ_DRAIN;
        end
      end
      tsio_pkg::SQ_DRAIN: begin
        if (tx_ready) begin
          s_d.hold_cnt = 32'(HOLD_CYCLES);
          s_d.sq_st    = tsio_pkg::SQ_HOLD;
        end
      end
      tsio_pkg::SQ_HOLD: begin
        s_d.hold_cnt = s_q.hold_cnt - 32'h1;
        if (s_q.hold_cnt == 32'h1) begin
          s_d.sq_rts = 1'b0;
          s_d.sq_st  = tsio_pkg::SQ_IDLE;
        end
      end
    endcase
    s_d.rd_valid = (rd_addr == refresh_addr) && !refresh_suspend;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Page memory: cursor write port, shared read port
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[cursor_addr] <= {rx_blink, rx_protect, s_q.rx_char};
    end
    rd_data_q <= mem_q[rd_addr];
  end

  assign refresh_data  = rd_data_q;
  assign refresh_valid = s_q.rd_valid;
  assign mem_write     = wr_en;
  assign txd_main      = brk_on ? 1'b0 : (s_q.route_aux ? 1'b1 : tx_out);
  assign txd_aux       = s_q.route_aux ? tx_out : 1'b1;
  assign rts           = s_q.sq_rts | s_q.kb_pend | ~tx_ready;
  assign dtr           = s_q.dtr;
  assign clk_x8_out    = s_q.x8;
  assign seq_busy      = (s_q.sq_st != tsio_pkg::SQ_IDLE);
endmodule
`default_nettype wire

/* rtl/tsio_uart_tx.sv */
// Serial character transmitter driven by a 16x bit-clock tick
`timescale 1ns/1ps
`default_nettype none
`include "tsio_defs.svh"
module tsio_uart_tx (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       tick16,
  input  wire logic       cts,
  input  wire logic       load,
  input  wire logic [6:0] data,
  input  wire logic       parity_en,
  input  wire logic       parity_odd,
  input  wire logic       two_stop,
  output logic            ready,
  output logic            txd
);
  tsio_pkg::tsio_tx_s s_q;
  tsio_pkg::tsio_tx_s s_d;
  logic               par;

  assign ready = ~s_q.busy;
  assign txd   = s_q.busy ? s_q.shift[0] : 1'b1;

  always_comb begin
    s_d = s_q;
    par = parity_odd ? ~^data : ^data;
    if (load && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.sub  = 4'h0;
      if (parity_en) begin
        s_d.shift     = {2'b11, par, data, 1'b0};
        s_d.bits_left = two_stop ? 4'd11 : 4'd10;
      end else begin
        s_d.shift     = {3'b111, data, 1'b0};
        s_d.bits_left = two_stop ? 4'd10 : 4'd9;
      end
    end else if (s_q.busy && tick16 && cts) begin
      s_d.sub = s_q.sub + 4'h1;
      if (s_q.sub == `TSIO_RX_LAST) begin
        s_d.shift     = {1'b1, s_q.shift[10:1]};
        s_d.bits_left = s_q.bits_left - 4'h1;
        if (s_q.bits_left == 4'h1) begin
          s_d.busy = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* tb/tsio_host_model.sv */
// Host end of one serial line: frame decoder and character sender
`timescale 1ns/1ps
`default_nettype none
module tsio_host_model #(
  parameter int BIT = 16
) (
  input  wire logic       clk_sys,
  input  wire logic       line,
  input  wire logic       par_en,
  input  wire logic       par_odd,
  input  wire logic       cts,
  output logic            got,
  output logic [7:0]      ch,
  output logic            rxd
);
  logic [6:0] d;
  logic       p;
  // Bit 7 of ch flags a parity or stop error
  initial begin
    got = 1'b0;
    ch  = 8'h00;
    rxd = 1'b1;
    forever begin
      @(negedge line);
      bits(BIT / 2);
      for (int i = 0; i < 7; i++) begin
        bits(BIT);
        d[i] = line;
      end
      p = 1'b0;
      if (par_en) begin
        bits(BIT);
        p = line != (^d ^ par_odd);
      end
      bits(BIT);
      ch  = {p | !line, d};
      got = 1'b1;
      @(posedge clk_sys);
      got = 1'b0;
    end
  end
  task automatic bits(input int n);
    repeat (n) do @(posedge clk_sys); while (!cts);
  endtask
  task automatic send(input logic [6:0] c);
    rxd = 1'b0;
    repeat (BIT) @(negedge clk_sys);
    for (int i = 0; i < 7; i++) begin
      rxd = c[i];
      repeat (BIT) @(negedge clk_sys);
    end
    if (par_en) begin
      rxd = ^c ^ par_odd;
      repeat (BIT) @(negedge clk_sys);
    end
    rxd = 1'b1;
    repeat (2 * BIT) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* tb/tsio_top_asserts.sv */
// Port-level checks for the terminal serial sequencer
`timescale 1ns/1ps
`default_nettype none
module tsio_top_asserts #(
  parameter int CLK_HZ = 40000000
) (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        term_ready,
  input wire logic        cts,
  input wire logic        kbd_break_n,
  input wire logic        send_key,
  input wire logic [10:0] cursor_addr,
  input wire logic        mem_write,
  input wire logic        txd_main,
  input wire logic        txd_aux,
  input wire logic        rts,
  input wire logic        dtr,
  input wire logic        clk_x8_out,
  input wire logic        seq_busy
);
  // Longest half period of the 8x clock, at the slowest rate
  localparam int LIM = CLK_HZ / 1200;
  logic [31:0] still_q;
  logic        x8_q;
  always_ff @(posedge clk_sys) begin
    x8_q    <= clk_x8_out;
    still_q <= (!reset_n || clk_x8_out != x8_q) ? 32'h0 : still_q + 32'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_dtr_copy: assert property ($past(reset_n) |-> dtr == $past(term_ready))
    else $error("dtr does not follow terminal ready");
  a_break_space: assert property ($fell(kbd_break_n) |-> ##[1:4] !txd_main [*8])
    else $error("break does not hold the line spacing");
  a_write_pulse: assert property (mem_write |=> !mem_write)
    else $error("write strobe longer than one cycle");
  a_hidden_rows: assert property (mem_write |-> cursor_addr < 11'd1920)
    else $error("write into hidden memory area");
  a_rts_busy: assert property (seq_busy |-> rts)
    else $error("sequencer active without request to send");
  a_send_start: assert property (send_key && !seq_busy |=> seq_busy && rts)
    else $error("send key did not start the sequencer");
  a_cts_hold: assert property (!cts && !$past(cts) |-> $stable(txd_main))
    else $error("main line moved while clear to send was low");
  a_aux_idle: assert property (!seq_busy |-> txd_aux)
    else $error("aux line active outside an aux send");
  a_x8_runs: assert property (still_q <= LIM)
    else $error("8x clock stopped");
endmodule
bind tsio_top tsio_top_asserts #(.CLK_HZ(CLK_HZ)) u_tsio_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .term_ready(term_ready), .cts(cts),
  .kbd_break_n(kbd_break_n), .send_key(send_key), .cursor_addr(cursor_addr),
  .mem_write(mem_write), .txd_main(txd_main), .txd_aux(txd_aux), .rts(rts),
  .dtr(dtr), .clk_x8_out(clk_x8_out), .seq_busy(seq_busy));
`default_nettype wire

/* tb/tsio_top_tb_top.sv */
// Self-checking bench for the terminal serial sequencer
`timescale 1ns/1ps
`default_nettype none
module tsio_top_tb_top;
  logic                clk_sys = 1'b0;
  logic                reset_n = 1'b0;
  tsio_pkg::tsio_cfg_s cfg;
  logic                term_ready, cts, bus_sel, kbd_load, kbd_break_n, send_key, aux_send_key, pkey;
  logic [6:0]          kbd_data, bus_data;
  logic [3:0]          pkey_idx;
  logic [10:0]         cursor_addr, refresh_addr;
  logic                rx_protect, rx_blink, refresh_req, refresh_suspend, refresh_valid, mem_write;
  logic [8:0]          refresh_data, last;
  logic                txd_main, txd_aux, rts, dtr, clk_x8_out, seq_busy, rxd_main, rxd_aux, hm_got, ha_got;
  logic [7:0]          hm_ch, ha_ch;
  logic [8:0]          q_main[$], q_aux[$], q_mem[$], mem_exp[0:80];
  logic [31:0]         r, seed = 32'heaefc475;
  int                  mismatches = 0, n_compared = 0, n_wr = 0;
  always #12.5 clk_sys = ~clk_sys;
  tsio_top #(.CLK_HZ(307200), .BREAK_MS(1), .RTS_HOLD_US(100)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .cfg(cfg), .term_ready(term_ready), .rxd_main(rxd_main),
    .rxd_aux(rxd_aux), .cts(cts), .kbd_data(kbd_data), .bus_data(bus_data), .bus_sel(bus_sel),
    .kbd_load(kbd_load), .kbd_break_n(kbd_break_n), .send_key(send_key), .aux_send_key(aux_send_key),
    .programmable_keys(pkey), .programmable_key_index(pkey_idx), .cursor_addr(cursor_addr),
    .rx_protect(rx_protect), .rx_blink(rx_blink), .refresh_req(refresh_req),
    .refresh_suspend(refresh_suspend), .refresh_addr(refresh_addr), .refresh_data(refresh_data),
    .refresh_valid(refresh_valid), .mem_write(mem_write), .txd_main(txd_main), .txd_aux(txd_aux),
    .rts(rts), .dtr(dtr), .clk_x8_out(clk_x8_out), .seq_busy(seq_busy));
  tsio_host_model host_m (.clk_sys(clk_sys), .line(txd_main), .par_en(cfg.parity_en),
    .par_odd(cfg.parity_odd), .cts(cts), .got(hm_got), .ch(hm_ch), .rxd(rxd_main));
  tsio_host_model host_a (.clk_sys(clk_sys), .line(txd_aux), .par_en(cfg.parity_en),
    .par_odd(cfg.parity_odd), .cts(cts), .got(ha_got), .ch(ha_ch), .rxd(rxd_aux));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((rts !== 1'b0 || seq_busy !== 1'b0) && n < 40000) begin
      @(negedge clk_sys);
      n++;
    end
    cmp({8'h0, n >= 40000}, 9'h000);
    repeat (60) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [10:0] a, input logic [8:0] e);
    refresh_addr = a;
    pulse(refresh_req);
    q_mem.push_back(e);
    repeat (3) @(negedge clk_sys);
    cmp(9'(q_mem.size()), 9'h000);
  endtask
  task automatic expect_block(ref logic [8:0] q[$], input logic fmt);
    q.push_back(9'o002);
    for (int i = 0; i < 81; i++) begin
      if (fmt && i > 0 && mem_exp[i][7] != mem_exp[i-1][7]) q.push_back(9'o111);
      if (!(fmt && mem_exp[i][7])) q.push_back({2'b0, mem_exp[i][6:0]});
      if (!fmt && i == 79) q.push_back(9'o015);
      if (!fmt && i == 79) q.push_back(9'o012);
    end
    q.push_back(9'o003);
  endtask
  // Results are matched against the oldest expectation as they appear
  always @(negedge clk_sys) begin
    if (hm_got) cmp({1'b0, hm_ch}, q_main.size() ? q_main.pop_front() : 9'bx);
    if (ha_got) cmp({1'b0, ha_ch}, q_aux.size() ? q_aux.pop_front() : 9'bx);
    if (refresh_valid && q_mem.size() != 0) cmp(refresh_data, q_mem.pop_front());
    if (mem_write === 1'b1) n_wr++;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    cmp(9'h001, 9'h000);
    report_and_stop();
  end
  initial begin
    cfg = '0;
    cfg.baud_sel = 4'h9;
    cfg.online = 1'b1;
    cfg.rx_src = 2'h2;
    {term_ready, cts, kbd_break_n} = 3'h7;
    {bus_sel, kbd_load, send_key, aux_send_key, pkey, rx_protect, rx_blink, refresh_req, refresh_suspend} = '0;
    {kbd_data, bus_data, pkey_idx, cursor_addr, refresh_addr} = '0;
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    cmp({4'h0, txd_main, txd_aux, rts, seq_busy, mem_write}, 9'h018);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      {cfg.two_stop, cfg.parity_odd, cfg.parity_en} = r[10:8];
      {term_ready, cfg.baud_sel[2:1]} = r[18:16];
      cursor_addr = i[0] ? 11'd1920 : 11'd1919;
      {rx_blink, rx_protect, bus_sel} = r[13:11];
      kbd_data = bus_sel ? ~r[6:0] : r[6:0];
      bus_data = bus_sel ? r[6:0] : ~r[6:0];
      q_main.push_back({2'b0, r[6:0]});
      if (!i[0]) last = {r[13:12], r[6:0]};
      pulse(kbd_load);
      wait_idle();
    end
    cmp(n_wr[8:0], 9'd3);
    rd(11'd1919, last);
    cfg.rx_src = 2'h0;
    for (int i = 0; i < 81; i++) begin
      r = xs();
      cursor_addr = i[10:0];
      rx_protect = (i == 2 || i == 3);
      rx_blink = r[9];
      {cts, refresh_req, cfg.format_mode} = r[12:10];
      mem_exp[i] = {r[9], rx_protect, r[6:0]};
      host_m.send(r[6:0]);
      repeat (4) @(negedge clk_sys);
    end
    cmp(n_wr[8:0], 9'd84);
    for (int i = 0; i < 81; i += 20) rd(i[10:0], mem_exp[i]);
    cfg.online = 1'b0;
    cursor_addr = 11'd500;
    host_m.send(7'h55);
    repeat (40) @(negedge clk_sys);
    cmp(n_wr[8:0], 9'd84);
    {cfg.online, cfg.rx_src, rx_blink, rx_protect} = 5'h14;
    cursor_addr = 11'd600;
    host_a.send(7'h2a);
    repeat (40) @(negedge clk_sys);
    rd(11'd600, 9'h02a);
    cfg.rx_src = 2'h3;
    cursor_addr = 11'd81;
    {cts, refresh_req, refresh_suspend, cfg.format_mode} = 4'he;
    expect_block(q_main, 1'b0);
    pulse(send_key);
    wait_idle();
    {refresh_req, refresh_suspend, cfg.format_mode} = 3'h1;
    expect_block(q_main, 1'b1);
    pulse(send_key);
    wait_idle();
    cfg.format_mode = 1'b0;
    expect_block(q_aux, 1'b0);
    pulse(aux_send_key);
    wait_idle();
    for (int k = 0; k < 16; k++) begin
      pkey_idx = k[3:0];
      q_main.push_back(9'o002);
      q_main.push_back(9'o033);
      q_main.push_back(9'h040 + k[8:0]);
      q_main.push_back(9'o003);
      if (k == 0) cts = 1'b0;
      pulse(pkey);
      if (k == 0) begin
        repeat (100) @(negedge clk_sys);
        cmp({7'h0, txd_main, rts}, 9'h003);
        cts = 1'b1;
      end
      wait_idle();
    end
    {cfg.parity_en, bus_sel, kbd_data} = 9'h07f;
    q_main.push_back(9'h07f);
    pulse(kbd_load);
    repeat (50) @(negedge clk_sys);
    cts = 1'b0;
    repeat (300) @(negedge clk_sys);
    cmp({8'h0, rts}, 9'h001);
    cts = 1'b1;
    wait_idle();
    q_main.push_back(9'h080);
    kbd_break_n = 1'b0;
    repeat (250) @(negedge clk_sys);
    cmp({8'h0, txd_main}, 9'h000);
    repeat (150) @(negedge clk_sys);
    kbd_break_n = 1'b1;
    cmp({8'h0, txd_main}, 9'h001);
    term_ready = 1'b0;
    repeat (60) @(negedge clk_sys);
    cmp({8'h0, dtr}, 9'h000);
    cmp(9'(q_main.size() + q_aux.size()), 9'h000);
    report_and_stop();
  end
endmodule
`default_nettype wire
